// *** nps_pkg.sv ***
// package: command codes, address layout and timing for the flash host
package nps_pkg;
   localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
   localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
   localparam logic [7:0] CMD_CACHE_READ   = 8'h31;
   localparam logic [7:0] CMD_CACHE_EXIT   = 8'h34;
   localparam logic [7:0] CMD_COPY_READ    = 8'h35;
   localparam logic [7:0] CMD_RAND_OUT     = 8'h05;
   localparam logic [7:0] CMD_RAND_OUT_CFM = 8'he0;
   localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
   localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_RAND_IN      = 8'h85;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam int COL_CYCLES  = 2;
   localparam int ADDR_CYCLES = 4;
   localparam int PAGE_BYTES  = 2112;
   localparam int MAX_PARTIAL = 8;
   localparam int CTRL_READY_BIT = 6;
   localparam int INT_READY_BIT  = 5;
   localparam int ERROR_BIT      = 0;
   // strobe timing in ns, cycles derived at 100 ns per clock
   localparam int CLK_NS      = 100;
   localparam int STROBE_NS   = 100;
   localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [2:0] {
      NPS_OP_READ, NPS_OP_CACHE_READ, NPS_OP_CACHE_EXIT, NPS_OP_RAND_OUT,
      NPS_OP_PROGRAM, NPS_OP_COPY_READ, NPS_OP_COPY_PROG, NPS_OP_STATUS
   } nps_op_t;
endpackage

// *** nps_strobe.sv ***
// one bus cycle on the flash pins: latch write or data read strobe
`timescale 1ns/10ps
module nps_strobe #(
   parameter int LOW_CYC = 1
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // request
   input  wire logic       start,
   input  wire logic       is_read,
   output logic            done,
   // strobes
   output logic            write_strobe_n,
   output logic            read_strobe_n
);
   typedef enum logic [1:0] {NPS_S_IDLE, NPS_S_LOW, NPS_S_HIGH} nps_sph_t;
   nps_sph_t   ph_r, ph_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic       rd_r, rd_nxt;

   always_comb begin
      ph_nxt = ph_r;
      cnt_nxt = cnt_r;
      rd_nxt = rd_r;
      done = 1'b0;
      case (ph_r)
         NPS_S_IDLE: if (start) begin
            ph_nxt = NPS_S_LOW;
            rd_nxt = is_read;
            cnt_nxt = 8'(LOW_CYC - 1);
         end
         NPS_S_LOW: if (cnt_r == 8'h00) begin
            ph_nxt = NPS_S_HIGH;
            cnt_nxt = 8'(LOW_CYC - 1);
         end else begin
            cnt_nxt = cnt_r - 8'h01;
         end
         NPS_S_HIGH: if (cnt_r == 8'h00) begin
            ph_nxt = NPS_S_IDLE;
            done = 1'b1;
         end else begin
            cnt_nxt = cnt_r - 8'h01;
         end
         default: ph_nxt = NPS_S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ph_r <= NPS_S_IDLE;
         cnt_r <= 8'h00;
         rd_r <= 1'b0;
      end else begin
         ph_r <= ph_nxt;
         cnt_r <= cnt_nxt;
         rd_r <= rd_nxt;
      end
   end

   // the device latches on the rising edge, i.e. leaving the low phase
   assign write_strobe_n = !(ph_r == NPS_S_LOW && !rd_r);
   assign read_strobe_n  = !(ph_r == NPS_S_LOW && rd_r);
endmodule

// *** nps_host.sv ***
// host sequencer driving page read, cache read, program and copy-back
`timescale 1ns/10ps
module nps_host #(
   parameter int ADDR_CYCLES = nps_pkg::ADDR_CYCLES,
   parameter int MAX_PARTIAL = nps_pkg::MAX_PARTIAL,
   parameter int PAGE_ADDR_W = 17
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // user request
   input  wire logic        op_valid,
   output logic             op_ready,
   input  wire nps_pkg::nps_op_t op_code,
   input  wire logic [11:0] op_column,
   input  wire logic [PAGE_ADDR_W-1:0] op_row,
   input  wire logic [15:0] op_count,
   // user write data
   input  wire logic [7:0]  wr_data,
   input  wire logic        wr_valid,
   output logic             wr_ready,
   // user read data and results
   output logic [7:0]       rd_data,
   output logic             rd_valid,
   output logic             op_done,
   output logic             op_error,
   output logic             op_refused,
   // flash pins
   output logic             command_latch_line,
   output logic             address_latch_line,
   output logic             write_strobe_n,
   output logic             read_strobe_n,
   output logic [7:0]       io_out,
   output logic             io_oe,
   input  wire logic [7:0]  io_in,
   input  wire logic        ready_busy_line
);
   typedef enum logic [3:0] {
      NPS_IDLE, NPS_CMD1, NPS_ADDR, NPS_DATA_IN, NPS_CMD2, NPS_WAIT_BUSY,
      NPS_WAIT_READY, NPS_STATUS_CMD, NPS_STATUS_RD, NPS_DATA_OUT
   } nps_state_t;

   nps_state_t st_r, st_nxt;
   nps_pkg::nps_op_t op_r, op_nxt;
   logic [11:0] col_r, col_nxt;
   logic [PAGE_ADDR_W-1:0] row_r, row_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [2:0]  acyc_r, acyc_nxt;
   logic        read_mode_r, read_mode_nxt;
   logic        cache_r, cache_nxt;
   logic        loaded_r, loaded_nxt;
   logic [3:0]  partial_r, partial_nxt;
   logic [PAGE_ADDR_W-1:0] last_row_r, last_row_nxt;
   logic [7:0]  io_r, io_nxt;
   logic [7:0]  rd_r, rd_nxt;
   logic        rdv_r, rdv_nxt, done_r, done_nxt, err_r, err_nxt;
   logic        ref_r, ref_nxt, cl_r, cl_nxt, al_r, al_nxt, oe_r, oe_nxt;
   logic        go, go_rd, bus_done;
   logic        rb_meta_r, rb_r;
   logic [39:0] addr_bytes;

   nps_strobe #(.LOW_CYC(nps_pkg::STROBE_CYC)) u_strobe (
      .clk            (clk),
      .rst            (rst),
      .start          (go),
      .is_read        (go_rd),
      .done           (bus_done),
      .write_strobe_n (write_strobe_n),
      .read_strobe_n  (read_strobe_n)
   );

   // ready/busy is asynchronous to us
   always_ff @(posedge clk) begin
      if (rst) begin
         rb_meta_r <= 1'b1;
         rb_r <= 1'b1;
      end else begin
         rb_meta_r <= ready_busy_line;
         rb_r <= rb_meta_r;
      end
   end

   // column in two bytes, then row bytes
   assign addr_bytes = {{(24-PAGE_ADDR_W){1'b0}}, row_r, 4'h0, col_r};

   always_comb begin
      st_nxt = st_r; op_nxt = op_r; col_nxt = col_r; row_nxt = row_r;
      cnt_nxt = cnt_r; acyc_nxt = acyc_r; read_mode_nxt = read_mode_r;
      cache_nxt = cache_r; loaded_nxt = loaded_r; partial_nxt = partial_r;
      last_row_nxt = last_row_r; io_nxt = io_r; rd_nxt = rd_r;
      cl_nxt = cl_r; al_nxt = al_r; oe_nxt = oe_r;
      rdv_nxt = 1'b0; done_nxt = 1'b0; err_nxt = err_r; ref_nxt = 1'b0;
      go = 1'b0; go_rd = 1'b0; wr_ready = 1'b0;
      op_ready = (st_r == NPS_IDLE);
      case (st_r)
         NPS_IDLE: if (op_valid) begin
            op_nxt = op_code; col_nxt = op_column; row_nxt = op_row;
            cnt_nxt = op_count; acyc_nxt = 3'd0; loaded_nxt = 1'b0;
            err_nxt = 1'b0;
            st_nxt = NPS_CMD1;
            // no random output in cache read
            if (op_code == nps_pkg::NPS_OP_RAND_OUT && cache_r)
               begin ref_nxt = 1'b1; st_nxt = NPS_IDLE; end
            // exit only meaningful inside cache read
            if (op_code == nps_pkg::NPS_OP_CACHE_EXIT && !cache_r)
               begin ref_nxt = 1'b1; st_nxt = NPS_IDLE; end
            // cache read must start at column zero
            if (op_code == nps_pkg::NPS_OP_CACHE_READ && op_column != 12'h000)
               begin ref_nxt = 1'b1; st_nxt = NPS_IDLE; end
            // eighth partial program is the last before erase
            if (op_code == nps_pkg::NPS_OP_PROGRAM && op_row == last_row_r &&
                partial_r >= 4'(MAX_PARTIAL))
               begin ref_nxt = 1'b1; st_nxt = NPS_IDLE; end
            // program with no data would not start
            if (op_code == nps_pkg::NPS_OP_PROGRAM && op_count == 16'h0000)
               begin ref_nxt = 1'b1; st_nxt = NPS_IDLE; end
            cl_nxt = (st_nxt == NPS_CMD1);
            oe_nxt = (st_nxt == NPS_CMD1);
            case (op_code)
               nps_pkg::NPS_OP_READ: io_nxt = read_mode_r ?
                  nps_pkg::CMD_READ_CONFIRM : nps_pkg::CMD_READ_SETUP;
               nps_pkg::NPS_OP_CACHE_EXIT: io_nxt = nps_pkg::CMD_CACHE_EXIT;
               nps_pkg::NPS_OP_RAND_OUT:   io_nxt = nps_pkg::CMD_RAND_OUT;
               nps_pkg::NPS_OP_PROGRAM:    io_nxt = nps_pkg::CMD_PROG_SETUP;
               nps_pkg::NPS_OP_COPY_PROG:  io_nxt = nps_pkg::CMD_RAND_IN;
               nps_pkg::NPS_OP_STATUS:     io_nxt = nps_pkg::CMD_READ_STATUS;
               default:                    io_nxt = nps_pkg::CMD_READ_SETUP;
            endcase
         end
         // command byte on the low lines with command latch high
         NPS_CMD1: begin
            go = 1'b1;
            st_nxt = NPS_CMD1;
            if (bus_done) begin
               cl_nxt = 1'b0;
               if (op_r == nps_pkg::NPS_OP_CACHE_EXIT) begin
                  cache_nxt = 1'b0; st_nxt = NPS_WAIT_BUSY;
                  oe_nxt = 1'b0;
               end else if (op_r == nps_pkg::NPS_OP_STATUS) begin
                  oe_nxt = 1'b0; st_nxt = NPS_STATUS_RD;
                  // device stays in status mode until a full read
                  read_mode_nxt = 1'b0;
               end else if (op_r == nps_pkg::NPS_OP_READ && read_mode_r) begin
                  oe_nxt = 1'b0; st_nxt = NPS_WAIT_BUSY;
               end else begin
                  al_nxt = 1'b1; io_nxt = addr_bytes[7:0]; st_nxt = NPS_ADDR;
               end
            end
         end
         // only the cycles the density needs are sent
         NPS_ADDR: begin
            go = 1'b1;
            if (bus_done) begin
               acyc_nxt = acyc_r + 3'd1;
               io_nxt = addr_bytes[8*(32'(acyc_r)+1) +: 8];
               // random output: column cycles only
               if ((op_r == nps_pkg::NPS_OP_RAND_OUT &&
                    acyc_r == 3'(nps_pkg::COL_CYCLES - 1)) ||
                   acyc_r == 3'(ADDR_CYCLES - 1)) begin
                  al_nxt = 1'b0;
                  if (op_r == nps_pkg::NPS_OP_PROGRAM) begin
                     st_nxt = NPS_DATA_IN;
                  end else begin
                     cl_nxt = 1'b1; st_nxt = NPS_CMD2;
                     case (op_r)
                        nps_pkg::NPS_OP_CACHE_READ:
                           io_nxt = nps_pkg::CMD_CACHE_READ;
                        nps_pkg::NPS_OP_COPY_READ:
                           io_nxt = nps_pkg::CMD_COPY_READ;
                        nps_pkg::NPS_OP_RAND_OUT:
                           io_nxt = nps_pkg::CMD_RAND_OUT_CFM;
                        nps_pkg::NPS_OP_COPY_PROG:
                           io_nxt = nps_pkg::CMD_PROG_CONFIRM;
                        default: io_nxt = nps_pkg::CMD_READ_CONFIRM;
                     endcase
                  end
               end
            end
         end
         // data words after the address, then confirm
         NPS_DATA_IN: begin
            // byte sits on the bus a cycle before its strobe starts
            go = loaded_r && cnt_r != 16'h0000;
            if (cnt_r == 16'h0000) begin
               cl_nxt = 1'b1; st_nxt = NPS_CMD2;
               io_nxt = nps_pkg::CMD_PROG_CONFIRM;
            end else if (!loaded_r) begin
               if (wr_valid) begin
                  wr_ready = 1'b1; io_nxt = wr_data; loaded_nxt = 1'b1;
               end
            end else if (bus_done) begin
               cnt_nxt = cnt_r - 16'h0001;
               loaded_nxt = 1'b0;
            end
         end
         NPS_CMD2: begin
            go = 1'b1;
            if (bus_done) begin
               cl_nxt = 1'b0; oe_nxt = 1'b0;
               st_nxt = (op_r == nps_pkg::NPS_OP_RAND_OUT) ?
                  NPS_DATA_OUT : NPS_WAIT_BUSY;
               read_mode_nxt = (op_r == nps_pkg::NPS_OP_READ);
               if (op_r == nps_pkg::NPS_OP_CACHE_READ) cache_nxt = 1'b1;
               if (op_r == nps_pkg::NPS_OP_PROGRAM) begin
                  partial_nxt = (row_r == last_row_r) ?
                     partial_r + 4'd1 : 4'd1;
                  last_row_nxt = row_r;
               end
            end
         end
         // acyc is free here; 7 marks the one spare cycle, count is kept
         NPS_WAIT_BUSY: begin
            if (!rb_r || acyc_r == 3'd7) st_nxt = NPS_WAIT_READY;
            else acyc_nxt = 3'd7;
         end
         // proceed only once ready/busy is high
         NPS_WAIT_READY: if (rb_r) begin
            if (op_r == nps_pkg::NPS_OP_PROGRAM ||
                op_r == nps_pkg::NPS_OP_COPY_PROG) begin
               cl_nxt = 1'b1; oe_nxt = 1'b1;
               io_nxt = nps_pkg::CMD_READ_STATUS;
               st_nxt = NPS_STATUS_CMD;
            end else if (op_r == nps_pkg::NPS_OP_COPY_READ ||
                         op_r == nps_pkg::NPS_OP_CACHE_EXIT) begin
               done_nxt = 1'b1; st_nxt = NPS_IDLE;
            end else begin
               cnt_nxt = op_count_len(cnt_r);
               st_nxt = NPS_DATA_OUT;
            end
         end
         NPS_STATUS_CMD: begin
            go = 1'b1;
            if (bus_done) begin
               cl_nxt = 1'b0; oe_nxt = 1'b0; st_nxt = NPS_STATUS_RD;
               read_mode_nxt = 1'b0;
            end
         end
         // status byte read and error flag taken
         NPS_STATUS_RD: begin
            go = 1'b1; go_rd = 1'b1;
            // bus is released soon after the strobe rises: take it while low
            if (!read_strobe_n) rd_nxt = io_in;
            if (bus_done) begin
               rdv_nxt = 1'b1; done_nxt = 1'b1;
               err_nxt = rd_r[nps_pkg::ERROR_BIT];
               st_nxt = NPS_IDLE;
            end
         end
         // one unit per read strobe until count spent
         NPS_DATA_OUT: begin
            go = cnt_r != 16'h0000; go_rd = 1'b1;
            if (!read_strobe_n) rd_nxt = io_in;
            if (cnt_r == 16'h0000) begin
               done_nxt = 1'b1; st_nxt = NPS_IDLE;
            end else if (bus_done) begin
               rdv_nxt = 1'b1;
               cnt_nxt = cnt_r - 16'h0001;
            end
         end
         default: st_nxt = NPS_IDLE;
      endcase
   end

   // zero length means the full page
   function automatic logic [15:0] op_count_len(input logic [15:0] n);
      op_count_len = (n == 16'h0000) ? 16'(nps_pkg::PAGE_BYTES) : n;
   endfunction

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= NPS_IDLE; op_r <= nps_pkg::NPS_OP_READ;
         col_r <= 12'h000; row_r <= '0; cnt_r <= 16'h0000; acyc_r <= 3'd0;
         read_mode_r <= 1'b0; cache_r <= 1'b0; loaded_r <= 1'b0;
         partial_r <= 4'h0; last_row_r <= '0; io_r <= 8'h00;
         rd_r <= 8'h00; rdv_r <= 1'b0; done_r <= 1'b0; err_r <= 1'b0;
         ref_r <= 1'b0; cl_r <= 1'b0; al_r <= 1'b0; oe_r <= 1'b0;
      end else begin
         st_r <= st_nxt; op_r <= op_nxt; col_r <= col_nxt; row_r <= row_nxt;
         cnt_r <= cnt_nxt; acyc_r <= acyc_nxt; read_mode_r <= read_mode_nxt;
         cache_r <= cache_nxt; loaded_r <= loaded_nxt;
         partial_r <= partial_nxt; last_row_r <= last_row_nxt;
         io_r <= io_nxt; rd_r <= rd_nxt; rdv_r <= rdv_nxt;
         done_r <= done_nxt; err_r <= err_nxt; ref_r <= ref_nxt;
         cl_r <= cl_nxt; al_r <= al_nxt; oe_r <= oe_nxt;
      end
   end

   assign command_latch_line = cl_r;
   assign address_latch_line = al_r;
   assign io_out = io_r;
   assign io_oe = oe_r;
   assign rd_data = rd_r;
   assign rd_valid = rdv_r;
   assign op_done = done_r;
   assign op_error = err_r;
   assign op_refused = ref_r;
endmodule

// *** nps_host_chk.sv ***
// checker of the host pin sequencing
`timescale 1ns/10ps
module nps_host_chk (
   // clock and reset
   input wire logic             clk,
   input wire logic             rst,
   // user side
   input wire logic             op_valid,
   input wire logic             op_ready,
   input wire nps_pkg::nps_op_t op_code,
   input wire logic [11:0]      op_column,
   input wire logic [15:0]      op_count,
   input wire logic             op_refused,
   // flash pins
   input wire logic             command_latch_line,
   input wire logic             address_latch_line,
   input wire logic             write_strobe_n,
   input wire logic             read_strobe_n,
   input wire logic [7:0]       io_out,
   input wire logic             io_oe,
   input wire logic             ready_busy_line
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire take = op_valid && op_ready;
   latch_excl_a:
   assert property (!(command_latch_line && address_latch_line))
      else $error("both latch lines high");
   strobe_excl_a:
   assert property (write_strobe_n || read_strobe_n)
      else $error("both strobes low");
   read_float_a:
   assert property (!read_strobe_n |-> !io_oe && !command_latch_line)
      else $error("host drives or latches during read");
   write_drive_a:
   assert property (!write_strobe_n |-> io_oe)
      else $error("write strobe without driven bus");
   cmd_stands_a:
   assert property ($fell(write_strobe_n) |=>
      $stable(io_out) && $stable(command_latch_line))
      else $error("command byte moved under strobe");
   cache_col_a:
   assert property (take && op_code == nps_pkg::NPS_OP_CACHE_READ
      && op_column != 12'h000 |=> op_refused)
      else $error("cache read with column not refused");
   prog_empty_a:
   assert property (take && op_code == nps_pkg::NPS_OP_PROGRAM
      && op_count == 16'h0000 |=> op_refused)
      else $error("empty program not refused");
   refuse_quiet_a:
   assert property (op_refused |-> $past(take) && write_strobe_n)
      else $error("refusal without request or with pin cycle");
   target_wait_a:
   assert property ($rose(write_strobe_n) && command_latch_line
      && io_out == nps_pkg::CMD_RAND_IN |-> ready_busy_line)
      else $error("target command while busy");
endmodule
bind nps_host nps_host_chk nps_host_chk_i (.clk(clk), .rst(rst),
   .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
   .op_column(op_column), .op_count(op_count), .op_refused(op_refused),
   .command_latch_line(command_latch_line),
   .address_latch_line(address_latch_line),
   .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
   .io_out(io_out), .io_oe(io_oe), .ready_busy_line(ready_busy_line));

// *** nps_flash_model.sv ***
// behavioural flash device answering the host pins
`timescale 1ns/10ps
module nps_flash_model #(
   parameter int BUSY_NS = 3000
) (
   // flash pins
   input wire logic       command_latch_line,
   input wire logic       address_latch_line,
   input wire logic       write_strobe_n,
   input wire logic       read_strobe_n,
   input wire logic [7:0] io_out,
   output logic [7:0]     io_in = 8'h5a,
   output logic           ready_busy_line = 1'b1,
   // commanded faults
   input wire logic       prog_fail
);
   logic [7:0]  addr [4];
   logic [7:0]  pbuf [8];
   logic [7:0]  last = 8'h5a;
   logic [15:0] row = 16'h0000;
   logic [11:0] col = 12'h000;
   int          n_addr = 0;
   int          n_data = 0;
   logic        stat_mode = 1'b0;
   logic        cache = 1'b0;
   logic        copy_ok = 1'b0;
   logic        fail = 1'b0;
   task automatic go_busy();
      ready_busy_line = 1'b0;
      ready_busy_line <= #(BUSY_NS) 1'b1;
   endtask
   // only status and exit pass while busy
   always @(posedge write_strobe_n) begin
      if (command_latch_line && (ready_busy_line || io_out == 8'h70
          || io_out == 8'h34)) begin
         n_addr = 0;
         stat_mode = 1'b0;
         // column and row taken at read, cache read and random output confirm
         if (io_out == 8'h30 || io_out == 8'h31 || io_out == 8'he0) begin
            col = {addr[1][3:0], addr[0]};
            row = {addr[3], addr[2]};
         end
         case (io_out)
            8'h30: go_busy();
            // latency only, later pages fetched on the fly
            8'h31: begin
               cache = 1'b1;
               go_busy();
            end
            8'h34: cache = 1'b0;
            8'h35: begin
               copy_ok = 1'b1;
               go_busy();
            end
            8'h70: stat_mode = 1'b1;
            8'h80: begin
               n_data = 0;
               copy_ok = 1'b0;
            end
            // program only with loaded data or copied page
            8'h10: if (n_data != 0 || copy_ok) begin
               fail = prog_fail;
               stat_mode = 1'b1;
               go_busy();
            end
            default: ;
         endcase
      end else if (address_latch_line) begin
         if (n_addr < 4) addr[n_addr] = io_out;
         n_addr++;
      end else if (!command_latch_line) begin
         if (n_data < 8) pbuf[n_data] = io_out;
         n_data++;
      end
   end
   // one unit per strobe, status byte in status mode
   always @(negedge read_strobe_n) begin
      #20;
      if (stat_mode) last = {3'b111, 4'h0, fail};
      else begin
         last = row[7:0] + col[7:0];
         col++;
         // next page follows at the page end
         if (cache && col == 12'd2112) begin
            col = 12'h000;
            row++;
         end
      end
      io_in = last;
   end
   // released bus shows the inverse so a stale byte never matches
   always @(posedge read_strobe_n) io_in <= #30 ~last;
endmodule

// *** test_nps_host.sv ***
// self-checking bench of the flash host sequencer
`timescale 1ns/10ps
module test_nps_host;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             op_valid = 1'b0;
   nps_pkg::nps_op_t op_code = nps_pkg::NPS_OP_STATUS;
   logic [11:0]      op_column = 12'h000;
   logic [16:0]      op_row = 17'h00000;
   logic [15:0]      op_count = 16'h0000;
   logic [7:0]       wr_data = 8'ha0;
   logic             wr_valid = 1'b1;
   logic             prog_fail = 1'b0;
   logic             op_ready, wr_ready, rd_valid, op_done, op_error;
   logic             op_refused, command_latch_line, address_latch_line;
   logic             write_strobe_n, read_strobe_n, io_oe, ready_busy_line;
   logic [7:0]       rd_data, io_out, io_in, w0;
   logic [7:0]       rbuf [16];
   logic             got_done, got_ref;
   int               fails = 0;
   int               cmp_count = 0;
   int               n_rd;
   always #50 clk = ~clk;
   nps_host nps_host_i (.*);
   nps_flash_model nps_flash_model_i (.*);
   // next byte offered once the host has consumed one
   always @(posedge clk) if (wr_ready === 1'b1) wr_data <= wr_data + 8'h01;
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         fails++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask
   task automatic run_op(input nps_pkg::nps_op_t c, input logic [11:0] col,
                         input logic [16:0] row, input logic [15:0] cnt);
      int i;
      @(posedge clk);
      #10;
      op_valid = 1'b1;
      op_code = c;
      op_column = col;
      op_row = row;
      op_count = cnt;
      for (i = 0; i < 50 && op_ready !== 1'b1; i++) @(posedge clk) #10;
      if (op_ready !== 1'b1) begin
         fails++;
         $display("FAIL %0t host never ready", $time);
         finish_test();
      end
      @(posedge clk);
      #10;
      op_valid = 1'b0;
      n_rd = 0;
      got_done = 1'b0;
      got_ref = 1'b0;
      for (i = 0; i < 20000; i++) begin
         if (rd_valid === 1'b1 && n_rd < 16) rbuf[n_rd] = rd_data;
         if (rd_valid === 1'b1) n_rd++;
         got_done = (op_done === 1'b1);
         got_ref = (op_refused === 1'b1);
         if (got_done || got_ref) break;
         @(posedge clk);
         #10;
      end
      if (!(got_done || got_ref)) begin
         fails++;
         $display("FAIL %0t operation hung", $time);
         finish_test();
      end
   endtask
   task automatic t_read();
      int i;
      run_op(nps_pkg::NPS_OP_READ, 12'h00a, 17'h5, 16'h0006);
      check(got_done && n_rd == 6, "read count");
      for (i = 0; i < 6; i++)
         check(rbuf[i] === 8'(15 + i), "read data");
      run_op(nps_pkg::NPS_OP_READ, 12'h00a, 17'h5, 16'h0002);
      check(got_done && rbuf[0] === 8'h0f, "repeat read");
   endtask
   task automatic t_rand_out();
      run_op(nps_pkg::NPS_OP_READ, 12'h000, 17'h5, 16'h0002);
      run_op(nps_pkg::NPS_OP_RAND_OUT, 12'h064, 17'h5, 16'h0002);
      check(got_done && rbuf[1] === 8'h6a, "column jump");
   endtask
   task automatic t_program();
      w0 = wr_data;
      run_op(nps_pkg::NPS_OP_PROGRAM, 12'h000, 17'h9, 16'h0003);
      check(got_done && op_error === 1'b0, "program ok");
      check(nps_flash_model_i.n_data == 3, "data count");
      check(nps_flash_model_i.pbuf[2] === w0 + 8'h02, "data order");
      prog_fail = 1'b1;
      run_op(nps_pkg::NPS_OP_PROGRAM, 12'h010, 17'ha, 16'h0001);
      check(got_done && op_error === 1'b1, "program error");
      prog_fail = 1'b0;
      run_op(nps_pkg::NPS_OP_STATUS, 12'h000, 17'h0, 16'h0001);
      check(rbuf[0] === 8'he1 && n_rd == 1, "status byte");
   endtask
   task automatic t_partial();
      int i;
      for (i = 0; i < 8; i++) begin
         run_op(nps_pkg::NPS_OP_PROGRAM, 12'(i), 17'hb, 16'h0001);
         check(got_done, "partial program");
      end
      run_op(nps_pkg::NPS_OP_PROGRAM, 12'h008, 17'hb, 16'h0001);
      check(got_ref, "ninth program");
   endtask
   task automatic t_refuse();
      run_op(nps_pkg::NPS_OP_PROGRAM, 12'h000, 17'hc, 16'h0000);
      check(got_ref, "empty program");
      run_op(nps_pkg::NPS_OP_CACHE_READ, 12'h001, 17'h2, 16'h0001);
      check(got_ref, "unaligned cache read");
      run_op(nps_pkg::NPS_OP_CACHE_EXIT, 12'h000, 17'h0, 16'h0000);
      check(got_ref, "exit outside cache");
   endtask
   task automatic t_cache();
      run_op(nps_pkg::NPS_OP_CACHE_READ, 12'h000, 17'h2, 16'h0003);
      check(got_done && rbuf[2] === 8'h04, "cache data");
      run_op(nps_pkg::NPS_OP_RAND_OUT, 12'h010, 17'h2, 16'h0001);
      check(got_ref, "jump in cache read");
      run_op(nps_pkg::NPS_OP_CACHE_EXIT, 12'h000, 17'h0, 16'h0000);
      check(got_done, "cache exit");
   endtask
   task automatic t_copy();
      run_op(nps_pkg::NPS_OP_COPY_READ, 12'h000, 17'h3, 16'h0000);
      check(got_done, "copy source");
      // rows 3, 4 and 5 share the top block bit
      run_op(nps_pkg::NPS_OP_COPY_PROG, 12'h000, 17'h4, 16'h0000);
      check(got_done && op_error === 1'b0, "copy target");
      prog_fail = 1'b1;
      run_op(nps_pkg::NPS_OP_COPY_PROG, 12'h000, 17'h5, 16'h0000);
      check(got_done && op_error === 1'b1, "copy failure");
      prog_fail = 1'b0;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #10;
      rst = 1'b0;
      t_read();
      t_rand_out();
      t_program();
      t_partial();
      t_refuse();
      t_cache();
      t_copy();
      finish_test();
   end
endmodule
